// ===== rtl/dmhi_host_port.sv
// host command and data port of the character display module
`timescale 1ns/1ps

module dmhi_host_port
	import dmhi_pkg::*;
#(
	parameter int unsigned RESET_DELAY_CYCLES = DMHI_RESET_DELAY_CYCLES
) (
	// clocks and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_srst,
	input  wire logic       i_sck,
	// jumper straps and reset pin
	input  wire logic [1:0] i_mode,
	input  wire logic       i_nibble_mode,
	input  wire logic       i_ext_rst_en,
	input  wire logic       i_ext_rst_n,
	// parallel bus
	input  wire logic [7:0] i_bus_lines,
	output logic [7:0]      o_bus_lines,
	output logic            o_bus_oe_n,
	input  wire logic       i_instr_data_sel,
	input  wire logic       i_dir,
	input  wire logic       i_latch_en,
	input  wire logic       i_wr_n,
	input  wire logic       i_rd_n,
	// serial link
	input  wire logic       i_frame_select,
	input  wire logic       i_sio,
	output logic            o_sio,
	output logic            o_sio_oe_n,
	// display core side
	output logic            o_wr_stb,
	output logic [7:0]      o_wr_data,
	output logic            o_wr_is_data,
	output logic            o_rd_stb,
	output logic            o_rd_is_data,
	input  wire logic [7:0] i_rd_data,
	output logic            o_core_rst
);

	localparam int GAP_CYC = DMHI_GAP_CYCLES;

	function automatic logic rise(input logic prev, input logic cur);
		rise = !prev && cur;
	endfunction

	// =====================================================================
	// pin synchronisers
	logic [DMHI_PIN_W-1:0] pin_raw;
	logic [DMHI_PIN_W-1:0] pin_meta;
	logic [DMHI_PIN_W-1:0] pin_s;

	assign pin_raw = {i_mode, i_nibble_mode, i_ext_rst_en, i_ext_rst_n, i_bus_lines,
		i_instr_data_sel, i_dir, i_latch_en, i_wr_n, i_rd_n, i_frame_select};

	// every pin but the serial clock and data passes two flops; straps follow the same path
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			pin_meta <= DMHI_PIN_IDLE;
			pin_s    <= DMHI_PIN_IDLE;
		end else begin
			pin_meta <= pin_raw;
			pin_s    <= pin_meta;
		end
	end

	dmhi_mode_t mode_s;
	logic       nib_s;
	logic       ext_en_s;
	logic       ext_rst_n_s;
	logic [7:0] bus_s;
	logic       rs_s;
	logic       dir_s;
	logic       e_s;
	logic       wr_n_s;
	logic       rd_n_s;
	logic       fs_s;

	// straps are only read here, never changed by commands
	assign mode_s      = dmhi_mode_t'(pin_s[18:17]);
	assign nib_s       = pin_s[16];
	assign ext_en_s    = pin_s[15];
	assign ext_rst_n_s = pin_s[14];
	assign bus_s       = pin_s[13:6];
	assign rs_s        = pin_s[5];
	assign dir_s       = pin_s[4];
	assign e_s         = pin_s[3];
	assign wr_n_s      = pin_s[2];
	assign rd_n_s      = pin_s[1];
	assign fs_s        = pin_s[0];

	// =====================================================================
	// reset control
	logic [31:0] pwr_cnt;
	logic        pwr_busy;
	logic        ext_hold;
	logic        rst_int;

	// power-up delay restarts on every system reset
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			pwr_cnt <= 32'(RESET_DELAY_CYCLES);
		end else if (pwr_cnt != 32'h0) begin
			pwr_cnt <= pwr_cnt - 32'h1;
		end
	end

	assign pwr_busy = (pwr_cnt != 32'h0);
	// the pin reset is ignored in serial mode
	assign ext_hold = ext_en_s && !ext_rst_n_s && (mode_s != DMHI_MODE_SERIAL);
	assign rst_int  = i_srst || pwr_busy || ext_hold;

	always_ff @(posedge i_ref_clk) begin
		o_core_rst <= rst_int;
	end

	// =====================================================================
	// strobe history and edges
	logic       e_d;
	logic       wr_n_d;
	logic       rd_n_d;
	logic       fs_d;
	logic [7:0] bus_d;
	logic       rs_d;

	// writes take bus and select from the sample before the edge; hold times are short
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			e_d    <= 1'b0;
			wr_n_d <= 1'b1;
			rd_n_d <= 1'b1;
			fs_d   <= 1'b1;
			bus_d  <= DMHI_BYTE_RST;
			rs_d   <= 1'b0;
		end else begin
			e_d    <= e_s;
			wr_n_d <= wr_n_s;
			rd_n_d <= rd_n_s;
			fs_d   <= fs_s;
			bus_d  <= bus_s;
			rs_d   <= rs_s;
		end
	end

	logic en_mode;
	logic sep_mode;
	logic ser_mode;
	logic wr_evt;
	logic rd_evt;
	logic rd_active;
	logic fs_rise;

	assign en_mode  = (mode_s == DMHI_MODE_ENABLE);
	assign sep_mode = (mode_s == DMHI_MODE_SEPARATE);
	assign ser_mode = (mode_s == DMHI_MODE_SERIAL);
	assign wr_evt   = (en_mode && rise(e_s, e_d) && !dir_s)
		|| (sep_mode && rise(wr_n_d, wr_n_s));
	assign rd_evt   = (en_mode && rise(e_d, e_s) && dir_s)
		|| (sep_mode && rise(rd_n_s, rd_n_d));
	assign rd_active = (en_mode && e_s && dir_s) || (sep_mode && !rd_n_s);
	assign fs_rise   = ser_mode && rise(fs_d, fs_s);

	// =====================================================================
	// nibble tracking
	logic       half_lo;
	logic [3:0] hi_nib;
	logic       rd_lo;

	// one flag for reads and writes; any reset brings back the upper half
	always_ff @(posedge i_ref_clk) begin
		if (rst_int || !nib_s) begin
			half_lo <= 1'b0;
		end else if (wr_evt || rd_evt) begin
			half_lo <= ~half_lo;
		end
	end

	// upper half parked until the lower half arrives
	always_ff @(posedge i_ref_clk) begin
		if (rst_int) begin
			hi_nib <= 4'h0;
			rd_lo  <= 1'b0;
		end else begin
			if (wr_evt && nib_s && !half_lo) begin
				hi_nib <= bus_d[7:4];
			end
			if (rd_evt) begin
				rd_lo <= nib_s && half_lo;
			end
		end
	end

	// =====================================================================
	// serial link and its crossing
	logic [7:0] rd_word;
	logic       ser_wr_tgl;
	logic [7:0] ser_wr_data;
	logic       ser_wr_rs;
	logic       ser_rd_tgl;
	logic       ser_rd_rs;

	dmhi_serial_link u_link (
		.i_sck          (i_sck),
		.i_clr          (o_core_rst),
		.i_frame_select (i_frame_select),
		.i_sio          (i_sio),
		.o_sio          (o_sio),
		.o_sio_oe_n     (o_sio_oe_n),
		.i_rd_word      (rd_word),
		.o_wr_tgl       (ser_wr_tgl),
		.o_wr_data      (ser_wr_data),
		.o_wr_rs        (ser_wr_rs),
		.o_rd_tgl       (ser_rd_tgl),
		.o_rd_rs        (ser_rd_rs)
	);

	logic [1:0] tg_meta;
	logic [1:0] tg_s;
	logic [1:0] tg_d;
	logic       wr_seen;
	logic       ser_rd_req;
	logic       ser_commit;

	// toggles cross in two flops; the words beside them are stable by then
	always_ff @(posedge i_ref_clk) begin
		if (rst_int) begin
			tg_meta <= 2'h0;
			tg_s    <= 2'h0;
			tg_d    <= 2'h0;
			wr_seen <= 1'b0;
		end else begin
			tg_meta <= {ser_rd_tgl, ser_wr_tgl};
			tg_s    <= tg_meta;
			tg_d    <= tg_s;
			if (fs_rise) begin
				wr_seen <= tg_s[0];
			end
		end
	end

	assign ser_rd_req = ser_mode && (tg_s[1] != tg_d[1]);
	// a finished write counts only once frame select has gone high again
	assign ser_commit = fs_rise && (tg_s[0] != wr_seen);

	// =====================================================================
	// write hand-off to the core
	always_ff @(posedge i_ref_clk) begin
		if (rst_int) begin
			o_wr_stb     <= 1'b0;
			o_wr_data    <= DMHI_BYTE_RST;
			o_wr_is_data <= 1'b0;
		end else begin
			o_wr_stb <= 1'b0;
			if (wr_evt && (!nib_s || half_lo)) begin
				o_wr_stb     <= 1'b1;
				o_wr_data    <= nib_s ? {hi_nib, bus_d[7:4]} : bus_d;
				o_wr_is_data <= rs_d;
			end else if (ser_commit) begin
				o_wr_stb     <= 1'b1;
				o_wr_data    <= ser_wr_data;
				o_wr_is_data <= ser_wr_rs;
			end
		end
	end

	// =====================================================================
	// read fetch: one request per byte, the lower nibble reuses it
	always_ff @(posedge i_ref_clk) begin
		if (rst_int) begin
			o_rd_stb     <= 1'b0;
			o_rd_is_data <= 1'b0;
			rd_word      <= DMHI_BYTE_RST;
		end else begin
			o_rd_stb <= 1'b0;
			if (rd_evt && (!nib_s || !half_lo)) begin
				o_rd_stb     <= 1'b1;
				o_rd_is_data <= rs_s;
			end else if (ser_rd_req) begin
				o_rd_stb     <= 1'b1;
				o_rd_is_data <= ser_rd_rs;
			end
			if (o_rd_stb) begin
				// dual-port memory inside never stalls, so busy stays clear
				rd_word <= o_rd_is_data ? i_rd_data : {1'b0, i_rd_data[6:0]};
			end
		end
	end

	// bus driven only while the read strobe is active
	always_ff @(posedge i_ref_clk) begin
		if (rst_int) begin
			o_bus_lines <= DMHI_BYTE_RST;
			o_bus_oe_n  <= 1'b1;
		end else begin
			o_bus_oe_n <= !rd_active;
			if (rd_lo) begin
				o_bus_lines <= {rd_word[3:0], 4'h0};
			end else if (nib_s) begin
				o_bus_lines <= {rd_word[7:4], 4'h0};
			end else begin
				o_bus_lines <= rd_word;
			end
		end
	end

	// =====================================================================
	// checks
	property p_byte_write;
		@(posedge i_ref_clk) disable iff (rst_int)
		(wr_evt && !nib_s) |=> o_wr_stb && o_wr_data == $past(bus_d)
			&& o_wr_is_data == $past(rs_d);
	endproperty
	a_byte_write: assert property (p_byte_write)
		else $error("byte write not passed to core");

	property p_nibble_pair;
		@(posedge i_ref_clk) disable iff (rst_int)
		(wr_evt && nib_s && half_lo) |=> o_wr_stb
			&& o_wr_data == {$past(hi_nib), $past(bus_d[7:4])};
	endproperty
	a_nibble_pair: assert property (p_nibble_pair)
		else $error("nibble pair assembled wrongly");

	property p_nibble_first;
		@(posedge i_ref_clk) disable iff (rst_int)
		(wr_evt && nib_s && !half_lo) |=> !o_wr_stb ##0 half_lo;
	endproperty
	a_nibble_first: assert property (p_nibble_first)
		else $error("upper nibble alone produced a write");

	property p_enable_write;
		@(posedge i_ref_clk) disable iff (rst_int)
		(en_mode && !nib_s && e_d && !e_s && !dir_s) |=> o_wr_stb;
	endproperty
	a_enable_write: assert property (p_enable_write)
		else $error("no write on enable falling edge");

	property p_sep_write;
		@(posedge i_ref_clk) disable iff (rst_int)
		(sep_mode && !nib_s && !wr_n_d && wr_n_s) |=> o_wr_stb;
	endproperty
	a_sep_write: assert property (p_sep_write)
		else $error("no write on write strobe rising edge");

	property p_read_drive;
		@(posedge i_ref_clk) disable iff (rst_int)
		(rd_evt && !nib_s) |-> ##2 (!o_bus_oe_n || !rd_active)
			##1 (o_bus_lines == rd_word || !rd_active);
	endproperty
	a_read_drive: assert property (p_read_drive)
		else $error("read data not driven on the bus");

	property p_busy_zero;
		@(posedge i_ref_clk) disable iff (rst_int)
		(o_rd_stb && !o_rd_is_data) |=> !rd_word[DMHI_BUSY_BIT];
	endproperty
	a_busy_zero: assert property (p_busy_zero)
		else $error("busy indication read as one");

	property p_reset_half;
		@(posedge i_ref_clk) rst_int |=> !half_lo && !o_wr_stb;
	endproperty
	a_reset_half: assert property (p_reset_half)
		else $error("nibble tracking not back at upper half");

	property p_ext_reset;
		@(posedge i_ref_clk) disable iff (i_srst)
		(ext_en_s && !ext_rst_n_s && !ser_mode) |=> o_core_rst;
	endproperty
	a_ext_reset: assert property (p_ext_reset)
		else $error("external reset pin ignored");

	property p_power_delay;
		@(posedge i_ref_clk) ($past(i_srst) && !i_srst) |-> rst_int [*8];
	endproperty
	a_power_delay: assert property (p_power_delay)
		else $error("internal reset released too early");

	property p_frame_invalid;
		@(posedge i_ref_clk) disable iff (rst_int)
		(fs_rise && tg_s[0] == wr_seen) |=> !o_wr_stb;
	endproperty
	a_frame_invalid: assert property (p_frame_invalid)
		else $error("write issued without a completed frame");

	property p_ser_read;
		@(posedge i_ref_clk) disable iff (rst_int)
		ser_rd_req |-> ##[1:GAP_CYC] o_rd_stb;
	endproperty
	a_ser_read: assert property (p_ser_read)
		else $error("serial read word not fetched inside the gap");

endmodule

// ===== rtl/dmhi_pkg.sv
// constants, types and field layout of the display module host port
//
// Summary of operation
// - parallel values move as byte or two nibbles
// - nibbles go upper half first on upper lines
// - select low means instruction, high means data
// - enable mode writes on strobe falling edge
// - enable mode reads drive bus after rising edge
// - separate strobes write on write strobe rising
// - separate strobes read after read strobe falling
// - serial cycle is two bytes, msb first
// - start byte direction high reads, low writes
// - start byte select marks instruction or data
// - serial write bits sampled on clock rising
// - serial read drives bits after falling edges
// - frame valid only when frame select rises
// - internal reset holds at least 100 ms
// - optional external reset pin in parallel modes
// - busy indication always reads as zero

package dmhi_pkg;

	// =====================================================================
	// interface modes, strapped by jumpers
	typedef enum logic [1:0] {
		DMHI_MODE_ENABLE   = 2'b00,
		DMHI_MODE_SEPARATE = 2'b01,
		DMHI_MODE_SERIAL   = 2'b11
	} dmhi_mode_t;

	// =====================================================================
	// timing
	localparam int unsigned DMHI_CLK_HZ             = 40_000_000;
	localparam int unsigned DMHI_CLK_NS             = 25;
	localparam int unsigned DMHI_RESET_DELAY_MS     = 100;
	localparam int unsigned DMHI_RESET_DELAY_CYCLES =
		(DMHI_CLK_HZ / 1000) * DMHI_RESET_DELAY_MS;
	localparam int unsigned DMHI_GAP_NS             = 1000;
	localparam int unsigned DMHI_GAP_CYCLES         =
		(DMHI_GAP_NS + DMHI_CLK_NS - 1) / DMHI_CLK_NS;

	// =====================================================================
	// serial start byte layout
	localparam int unsigned DMHI_SB_MARK_HI  = 7;
	localparam int unsigned DMHI_SB_MARK_LO  = 3;
	localparam logic [4:0]  DMHI_SB_MARK     = 5'h1f;
	localparam int unsigned DMHI_SB_RW_BIT   = 2;
	localparam int unsigned DMHI_SB_RS_BIT   = 1;
	localparam int unsigned DMHI_SB_ZERO_BIT = 0;
	localparam logic [4:0]  DMHI_SB_LAST     = 5'h07;
	localparam logic [4:0]  DMHI_DB_FIRST    = 5'h08;
	localparam logic [4:0]  DMHI_DB_LAST     = 5'h0f;
	localparam logic [4:0]  DMHI_FRAME_BITS  = 5'h10;

	// =====================================================================
	// read word layout and reset values
	localparam int unsigned DMHI_BUSY_BIT  = 7;
	localparam logic [7:0]  DMHI_BYTE_RST  = 8'h00;
	localparam int unsigned DMHI_PIN_W     = 19;
	// straps 0, reset pin high, strobes idle, frame select high
	localparam logic [18:0] DMHI_PIN_IDLE  = 19'h04007;

endpackage

// ===== rtl/dmhi_serial_link.sv
// serial shift logic of the host port, clocked by the host's shift clock
`timescale 1ns/1ps

module dmhi_serial_link
	import dmhi_pkg::*;
(
	// link clock and clears
	input  wire logic       i_sck,
	input  wire logic       i_clr,
	input  wire logic       i_frame_select,
	// serial line
	input  wire logic       i_sio,
	output logic            o_sio,
	output logic            o_sio_oe_n,
	// words to and from the core clock domain
	input  wire logic [7:0] i_rd_word,
	output logic            o_wr_tgl,
	output logic [7:0]      o_wr_data,
	output logic            o_wr_rs,
	output logic            o_rd_tgl,
	output logic            o_rd_rs
);

	// =====================================================================
	// frame state, cleared while frame select is high
	logic       frame_clr;
	logic [4:0] cnt;
	logic [6:0] shift;
	logic       cyc_ok;
	logic       cyc_rw;
	logic       cyc_rs;
	logic [7:0] byte_next;

	// the clock stands still outside frames, so the frame's own level ends it
	assign frame_clr = i_frame_select | i_clr;
	assign byte_next = {shift, i_sio};

	// bit counter and msb-first shifter on rising edges
	always_ff @(posedge i_sck or posedge frame_clr) begin
		if (frame_clr) begin
			cnt    <= 5'h00;
			shift  <= 7'h00;
			cyc_ok <= 1'b0;
			cyc_rw <= 1'b0;
			cyc_rs <= 1'b0;
		end else begin
			if (cnt != DMHI_FRAME_BITS) begin
				cnt <= cnt + 5'h01;
			end
			shift <= byte_next[6:0];
			if (cnt == DMHI_SB_LAST) begin
				// five ones and a trailing zero, else the frame is ignored
				cyc_ok <= (byte_next[DMHI_SB_MARK_HI:DMHI_SB_MARK_LO] == DMHI_SB_MARK)
					&& !byte_next[DMHI_SB_ZERO_BIT];
				cyc_rw <= byte_next[DMHI_SB_RW_BIT];
				cyc_rs <= byte_next[DMHI_SB_RS_BIT];
			end
		end
	end

	// =====================================================================
	// hand-off toggles, kept across frames so the core sees them after
	always_ff @(posedge i_sck or posedge i_clr) begin
		if (i_clr) begin
			o_wr_tgl  <= 1'b0;
			o_wr_data <= DMHI_BYTE_RST;
			o_wr_rs   <= 1'b0;
			o_rd_tgl  <= 1'b0;
			o_rd_rs   <= 1'b0;
		end else begin
			if (cnt == DMHI_SB_LAST
				&& byte_next[DMHI_SB_MARK_HI:DMHI_SB_MARK_LO] == DMHI_SB_MARK
				&& !byte_next[DMHI_SB_ZERO_BIT] && byte_next[DMHI_SB_RW_BIT]) begin
				o_rd_tgl <= ~o_rd_tgl;
				o_rd_rs  <= byte_next[DMHI_SB_RS_BIT];
			end
			if (cnt == DMHI_DB_LAST && cyc_ok && !cyc_rw) begin
				o_wr_tgl  <= ~o_wr_tgl;
				o_wr_data <= byte_next;
				o_wr_rs   <= cyc_rs;
			end
		end
	end

	// =====================================================================
	// read data goes out after each falling edge of the second byte;
	// the core has held i_rd_word stable since well inside the byte gap
	always_ff @(negedge i_sck or posedge frame_clr) begin
		if (frame_clr) begin
			o_sio      <= 1'b1;
			o_sio_oe_n <= 1'b1;
		end else if (cyc_ok && cyc_rw && cnt >= DMHI_DB_FIRST && cnt <= DMHI_DB_LAST) begin
			o_sio_oe_n <= 1'b0;
			o_sio      <= i_rd_word[3'(~cnt[2:0])];
		end
	end

	// =====================================================================
	// checks
	property p_start_reject;
		@(posedge i_sck) disable iff (frame_clr)
		(cnt == DMHI_SB_LAST && byte_next[DMHI_SB_ZERO_BIT]) |=> !cyc_ok;
	endproperty
	a_start_reject: assert property (p_start_reject)
		else $error("start byte with low bit set was accepted");

	property p_wr_capture;
		@(posedge i_sck) disable iff (i_clr)
		(cnt == DMHI_DB_LAST && cyc_ok && !cyc_rw)
			|=> (o_wr_tgl != $past(o_wr_tgl)) && (o_wr_data == $past(byte_next));
	endproperty
	a_wr_capture: assert property (p_wr_capture)
		else $error("serial write byte not handed over");

endmodule

// ===== verif/dmhi_host_model.sv
// host-side model: parallel bus master and serial link master
`timescale 1ns/1ps

module dmhi_host_model (
	// pacing clock and resolved wire levels
	input  wire logic       i_ref_clk,
	input  wire logic [7:0] i_bus,
	input  wire logic       i_sio,
	// parallel pins
	output logic [7:0]      o_bus,
	output logic            o_bus_drv,
	output logic            o_sel,
	output logic            o_dir,
	output logic            o_latch_en,
	output logic            o_wr_n,
	output logic            o_rd_n,
	// serial pins
	output logic            o_frame_select,
	output logic            o_sck,
	output logic            o_sio,
	output logic            o_sio_drv
);
	// idle pins; shift clock stands high outside frames
	initial begin
		{o_bus, o_bus_drv, o_sel, o_dir, o_latch_en} = '0;
		{o_wr_n, o_rd_n, o_frame_select, o_sck, o_sio, o_sio_drv} = 6'h3e;
	end

	// =====================================================================
	// parallel transfers, strobes held 10 cycles so slow syncs see them
	task automatic par_xfer(input logic sep, input logic rd, input logic sel,
		input logic [7:0] val, output logic [7:0] got);
		@(negedge i_ref_clk);
		o_sel = sel;
		o_dir = rd;
		o_bus = val;
		o_bus_drv = !rd;
		repeat (2) @(negedge i_ref_clk);
		if (sep) begin
			o_rd_n = !rd;
			o_wr_n = rd;
		end else begin
			o_latch_en = 1'b1;
		end
		repeat (10) @(negedge i_ref_clk);
		got = i_bus;
		o_latch_en = 1'b0;
		o_wr_n = 1'b1;
		o_rd_n = 1'b1;
		// hold data past the closing edge
		repeat (2) @(negedge i_ref_clk);
		o_bus_drv = 1'b0;
		repeat (8) @(negedge i_ref_clk);
	endtask

	// =====================================================================
	// serial frames: one bit per 48 ns clock, msb first
	task automatic ser_bit(input logic b, output logic s);
		o_sck = 1'b0;
		o_sio = b;
		#24;
		o_sck = 1'b1;
		s = i_sio;
		#24;
	endtask

	task automatic ser_frame(input logic [7:0] start, input logic [7:0] data,
		output logic [7:0] got);
		o_frame_select = 1'b0;
		o_sio_drv = 1'b1;
		#100;
		for (int i = 7; i >= 0; i--) ser_bit(start[i], got[i]);
		#1000; // inter_byte_gap, clock held still
		o_sio_drv = !start[2]; // release the line for reads
		for (int i = 7; i >= 0; i--) ser_bit(data[i], got[i]);
		#100;
		o_frame_select = 1'b1; // frame counts only on this rise
		o_sio_drv = 1'b0;
		#600;
	endtask
endmodule

// ===== verif/dmhi_host_port_test.sv
// self-checking bench for the display module host port
`timescale 1ns/1ps

module dmhi_host_port_test
	import dmhi_pkg::*;
;
	logic       clk;
	logic       srst;
	logic [1:0] mode;
	logic       nib;
	logic       xr_en;
	logic       xr_n;
	logic [7:0] bus_w;
	logic [7:0] h_bus;
	logic       h_drv;
	logic [7:0] d_bus;
	logic       d_oe_n;
	logic       sel;
	logic       dir;
	logic       len;
	logic       wr_n;
	logic       rd_n;
	logic       fs;
	logic       sck;
	logic       sio_w;
	logic       h_sio;
	logic       h_sdrv;
	logic       d_sio;
	logic       sio_oe_n;
	logic       wr_stb;
	logic [7:0] wr_data;
	logic       wr_isd;
	logic       rd_stb;
	logic       rd_isd;
	logic [7:0] rd_data;
	logic       core_rst;
	logic [7:0] wr_cnt;
	logic [7:0] rd_cnt;
	logic [7:0] exp_wr;
	int         err_total;
	int         cmp_count;

	// wire levels: the bus and serial data lines carry pull-ups
	assign bus_w   = !d_oe_n ? d_bus : (h_drv ? h_bus : 8'hff);
	assign sio_w   = !sio_oe_n ? d_sio : (h_sdrv ? h_sio : 1'b1);
	// display core answers in the strobe cycle
	assign rd_data = rd_isd ? 8'ha5 : 8'hc3;

	dmhi_host_port #(.RESET_DELAY_CYCLES(16)) dut_u (
		.i_ref_clk(clk), .i_srst(srst), .i_sck(sck), .i_mode(mode),
		.i_nibble_mode(nib), .i_ext_rst_en(xr_en), .i_ext_rst_n(xr_n),
		.i_bus_lines(bus_w), .o_bus_lines(d_bus), .o_bus_oe_n(d_oe_n),
		.i_instr_data_sel(sel), .i_dir(dir), .i_latch_en(len), .i_wr_n(wr_n),
		.i_rd_n(rd_n), .i_frame_select(fs), .i_sio(sio_w), .o_sio(d_sio),
		.o_sio_oe_n(sio_oe_n), .o_wr_stb(wr_stb), .o_wr_data(wr_data),
		.o_wr_is_data(wr_isd), .o_rd_stb(rd_stb), .o_rd_is_data(rd_isd),
		.i_rd_data(rd_data), .o_core_rst(core_rst));

	dmhi_host_model hm_u (
		.i_ref_clk(clk), .i_bus(bus_w), .i_sio(sio_w), .o_bus(h_bus),
		.o_bus_drv(h_drv), .o_sel(sel), .o_dir(dir), .o_latch_en(len),
		.o_wr_n(wr_n), .o_rd_n(rd_n), .o_frame_select(fs), .o_sck(sck),
		.o_sio(h_sio), .o_sio_drv(h_sdrv));

	// =====================================================================
	// clock and strobe counters
	initial begin
		clk = 1'b0;
		forever #12.5 clk = !clk;
	end

	always @(posedge clk) begin
		if (wr_stb === 1'b1) begin
			wr_cnt <= wr_cnt + 8'h01;
		end
		// fetches counted apart, the lower nibble read must not add one
		if (rd_stb === 1'b1) begin
			rd_cnt <= rd_cnt + 8'h01;
		end
	end

	// =====================================================================
	// checking and closing
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// one pulse per transfer, word and kind held afterwards
	task automatic wr_chk(input logic isd, input logic [7:0] val);
		exp_wr = exp_wr + 8'h01;
		check("write count", wr_cnt, exp_wr);
		check("write data", wr_data, val);
		check("write kind", {7'h0, wr_isd}, {7'h0, isd});
	endtask

	task automatic wait_ready(output int k);
		k = 0;
		while (core_rst !== 1'b0 && k < 200) begin
			@(negedge clk);
			k++;
		end
		repeat (4) @(negedge clk);
	endtask

	// mode and nibble straps change only under reset, as jumpers would
	task automatic restart(input logic [1:0] m, input logic n);
		int k;
		@(negedge clk);
		mode = m;
		nib = n;
		srst = 1'b1;
		repeat (12) @(negedge clk);
		srst = 1'b0;
		wait_ready(k);
		check("power-up delay", {7'h0, k >= 16 && k < 200}, 8'h01);
	endtask

	// watchdog: the tests need about 25 us
	initial begin
		#300_000;
		err_total++;
		give_verdict();
	end

	// =====================================================================
	// test sequence
	initial begin
		logic [7:0] g;
		int         k;
		srst = 1'b1;
		mode = 2'b00;
		nib = 1'b0;
		xr_en = 1'b0;
		xr_n = 1'b1;
		wr_cnt = 8'h00;
		rd_cnt = 8'h00;
		exp_wr = 8'h00;
		err_total = 0;
		cmp_count = 0;
		restart(DMHI_MODE_ENABLE, 1'b0);
		hm_u.par_xfer(1'b0, 1'b0, 1'b0, 8'h81, g);
		wr_chk(1'b0, 8'h81);
		hm_u.par_xfer(1'b0, 1'b0, 1'b1, 8'h7e, g);
		wr_chk(1'b1, 8'h7e);
		hm_u.par_xfer(1'b0, 1'b1, 1'b1, 8'h00, g);
		check("enable read", g, 8'ha5);
		hm_u.par_xfer(1'b0, 1'b1, 1'b0, 8'h00, g);
		check("busy bit read", g, 8'h43);
		// nibbles: lower lines carry junk that must be ignored
		restart(DMHI_MODE_ENABLE, 1'b1);
		hm_u.par_xfer(1'b0, 1'b0, 1'b1, 8'h3f, g);
		hm_u.par_xfer(1'b0, 1'b0, 1'b1, 8'hc0, g);
		wr_chk(1'b1, 8'h3c);
		hm_u.par_xfer(1'b0, 1'b1, 1'b1, 8'h00, g);
		check("nibble read upper", g, 8'ha0);
		hm_u.par_xfer(1'b0, 1'b1, 1'b1, 8'h00, g);
		check("nibble read lower", g, 8'h50);
		check("read fetches", rd_cnt, 8'h03);
		// external reset after a lone upper half
		xr_en = 1'b1;
		hm_u.par_xfer(1'b0, 1'b0, 1'b0, 8'h50, g);
		xr_n = 1'b0;
		repeat (6) @(negedge clk);
		check("external reset", {7'h0, core_rst}, 8'h01);
		xr_n = 1'b1;
		wait_ready(k);
		hm_u.par_xfer(1'b0, 1'b0, 1'b0, 8'h90, g);
		hm_u.par_xfer(1'b0, 1'b0, 1'b0, 8'h60, g);
		wr_chk(1'b0, 8'h96);
		xr_en = 1'b0;
		// separate strobes
		restart(DMHI_MODE_SEPARATE, 1'b0);
		hm_u.par_xfer(1'b1, 1'b0, 1'b1, 8'h5a, g);
		wr_chk(1'b1, 8'h5a);
		hm_u.par_xfer(1'b1, 1'b1, 1'b0, 8'h00, g);
		check("strobe read", g, 8'h43);
		check("bus released", {7'h0, d_oe_n}, 8'h01);
		// serial frames: writes, a malformed start byte, reads
		restart(DMHI_MODE_SERIAL, 1'b0);
		hm_u.ser_frame(8'hf8, 8'h81, g);
		wr_chk(1'b0, 8'h81);
		hm_u.ser_frame(8'hfa, 8'h3e, g);
		wr_chk(1'b1, 8'h3e);
		hm_u.ser_frame(8'hf9, 8'h55, g);
		check("bad start ignored", wr_cnt, exp_wr);
		hm_u.ser_frame(8'hfe, 8'h00, g);
		check("serial read", g, 8'ha5);
		hm_u.ser_frame(8'hfc, 8'h00, g);
		check("serial instr read", g, 8'h43);
		check("read fetches", rd_cnt, 8'h06);
		check("line released", {7'h0, sio_oe_n}, 8'h01);
		// the reset pin has no effect in serial mode
		@(negedge clk);
		xr_en = 1'b1;
		xr_n = 1'b0;
		repeat (6) @(negedge clk);
		check("reset pin in serial", {7'h0, core_rst}, 8'h00);
		xr_n = 1'b1;
		give_verdict();
	end
endmodule
